// file: pkg/arf_map.vh
// Register offsets, field positions and timing constants of the result formatter
`ifndef ARF_MAP_VH
`define ARF_MAP_VH
`define ARF_OFF_RESULT_HIGH 12'h000
`define ARF_OFF_RESULT_LOW 12'h004
`define ARF_OFF_CONTROL_A 12'h008
`define ARF_OFF_CONFIG_B 12'h00C
`define ARF_OFF_ACQ_STATUS 12'h010
`define ARF_CTL_ENABLE 0
`define ARF_CTL_BUSY 1
`define ARF_CTL_CHAN_LO 2
`define ARF_CTL_CHAN_HI 6
`define ARF_CFG_ALIGN 7
`define ARF_CFG_WMASK 8'hF7
`define ARF_CTL_WMASK 8'h7D
`define ARF_CLK_MHZ 25
`define ARF_TACQ_NS 4620
`define ARF_ACQ_CYCLES ((`ARF_TACQ_NS * `ARF_CLK_MHZ + 999) / 1000)
`define ARF_CONV_CYCLES 12
`endif

// file: core/arf_align.v
// Places a 10-bit result into the high and low result bytes
`timescale 1ns/10ps
`default_nettype none
module arf_align
(
  // Selection
  input wire right_just,
  // Result
  input wire [9:0] conversion_result,
  // Formatted bytes
  output reg [7:0] high_byte,
  output reg [7:0] low_byte
);
  always @*
  begin
    if (right_just)
    begin
      high_byte = {6'h00, conversion_result[9:8]};
      low_byte = conversion_result[7:0];
    end
    else
    begin
      high_byte = conversion_result[9:2];
      low_byte = {conversion_result[1:0], 6'h00};
    end
  end
endmodule
`default_nettype wire

// file: core/arf_top.v
// Converter control, result formatting and APB register access
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "arf_map.vh"
//
// Contract
// - Left format: low bits in low byte 7:6
// - Right format: bits 9:8 in high byte 1:0
// - Right format: low byte holds bits 7:0
// - Result is unsigned ten-bit code
// - Result bytes read/write, kept over resets
// - Left format: high byte holds bits 9:2
// - Align bit selects format, zeroes unused bits
// - Busy bit clears at completion; set together with enable starts
module arf_top
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Converter core
  input wire [9:0] conversion_result,
  output wire converter_enable,
  output wire [4:0] input_channel_select,
  output wire [2:0] conversion_clock_select,
  output wire negative_ref_select,
  output wire [1:0] positive_ref_select,
  output wire conversion_done
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  localparam [31:0] CONV_LAST_W = `ARF_CONV_CYCLES - 1;
  localparam [31:0] ACQ_CYCLES_W = `ARF_ACQ_CYCLES;
  localparam [3:0] CONV_LAST = CONV_LAST_W[3:0];
  localparam [7:0] ACQ_CYCLES = ACQ_CYCLES_W[7:0];

  reg [7:0] result_high_byte;
  reg [7:0] result_low_byte;
  reg [7:0] converter_control_a;
  reg [7:0] converter_config_b;
  reg state;
  reg [3:0] conv_cnt;
  reg [7:0] acq_cnt;
  reg start_early;
  reg done_pulse;
  reg [9:0] sample;
  wire [7:0] fmt_high;
  wire [7:0] fmt_low;
  wire wr_en;
  wire rd_en;
  wire hit;
  wire busy_set;
  wire acq_done;
  wire chan_change;

  assign pready = 1'b1;
  assign hit = (paddr == `ARF_OFF_RESULT_HIGH) || (paddr == `ARF_OFF_RESULT_LOW) ||
               (paddr == `ARF_OFF_CONTROL_A) || (paddr == `ARF_OFF_CONFIG_B) ||
               (paddr == `ARF_OFF_ACQ_STATUS);
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_en = psel & ~penable & ~pwrite;
  assign busy_set = wr_en && (paddr == `ARF_OFF_CONTROL_A) && pwdata[`ARF_CTL_BUSY];
  assign acq_done = (acq_cnt >= ACQ_CYCLES);
  assign chan_change = wr_en && (paddr == `ARF_OFF_CONTROL_A) &&
                       (pwdata[`ARF_CTL_CHAN_HI:`ARF_CTL_CHAN_LO] != input_channel_select);
  assign converter_enable = converter_control_a[`ARF_CTL_ENABLE];
  assign input_channel_select = converter_control_a[`ARF_CTL_CHAN_HI:`ARF_CTL_CHAN_LO];
  assign conversion_clock_select = converter_config_b[6:4];
  assign negative_ref_select = converter_config_b[2];
  assign positive_ref_select = converter_config_b[1:0];
  assign conversion_done = done_pulse;

  arf_align i_arf_align
  (
    .right_just(converter_config_b[`ARF_CFG_ALIGN]),
    .conversion_result(sample),
    .high_byte(fmt_high),
    .low_byte(fmt_low)
  );

  // Control registers and conversion sequencer
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converter_control_a <= 8'h00;
      converter_config_b <= 8'h00;
      state <= ST_IDLE;
      conv_cnt <= 4'h0;
      done_pulse <= 1'b0;
      sample <= 10'h000;
      acq_cnt <= 8'h00;
      start_early <= 1'b0;
    end
    else
    begin
      done_pulse <= 1'b0;
      if (wr_en && (paddr == `ARF_OFF_CONFIG_B))
        converter_config_b <= pwdata[7:0] & `ARF_CFG_WMASK;
      // Acquisition timer restarts on channel change
      if (chan_change)
        acq_cnt <= 8'h00;
      else if (!acq_done)
        acq_cnt <= acq_cnt + 8'h01;
      // A start written together with a new channel is early too
      if (busy_set && (!acq_done || chan_change))
        start_early <= 1'b1;
      else if (wr_en && (paddr == `ARF_OFF_ACQ_STATUS) && pwdata[1])
        start_early <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (wr_en && (paddr == `ARF_OFF_CONTROL_A))
            converter_control_a <= pwdata[7:0] & `ARF_CTL_WMASK;
          if (busy_set && pwdata[`ARF_CTL_ENABLE])
          begin
            converter_control_a[`ARF_CTL_BUSY] <= 1'b1;
            conv_cnt <= 4'h0;
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (wr_en && (paddr == `ARF_OFF_CONTROL_A))
          begin
            converter_control_a <= (pwdata[7:0] & `ARF_CTL_WMASK) | 8'h02;
            if (!pwdata[`ARF_CTL_BUSY] || !pwdata[`ARF_CTL_ENABLE])
            begin
              converter_control_a[`ARF_CTL_BUSY] <= 1'b0;
              state <= ST_IDLE;
            end
          end
          else if (conv_cnt == CONV_LAST)
          begin
            sample <= conversion_result;
            converter_control_a[`ARF_CTL_BUSY] <= 1'b0;
            done_pulse <= 1'b1;
            state <= ST_IDLE;
          end
          else
            conv_cnt <= conv_cnt + 4'h1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Result bytes have no reset: undefined at power-on, kept otherwise
  always @(posedge clk)
  begin
    if (done_pulse)
    begin
      result_high_byte <= fmt_high;
      result_low_byte <= fmt_low;
    end
    else if (wr_en && (paddr == `ARF_OFF_RESULT_HIGH))
      result_high_byte <= pwdata[7:0];
    else if (wr_en && (paddr == `ARF_OFF_RESULT_LOW))
      result_low_byte <= pwdata[7:0];
  end

  // Read data registered in the setup cycle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (paddr)
        `ARF_OFF_RESULT_HIGH: prdata <= {24'h000000, result_high_byte};
        `ARF_OFF_RESULT_LOW: prdata <= {24'h000000, result_low_byte};
        `ARF_OFF_CONTROL_A: prdata <= {24'h000000, converter_control_a};
        `ARF_OFF_CONFIG_B: prdata <= {24'h000000, converter_config_b};
        `ARF_OFF_ACQ_STATUS: prdata <= {30'h00000000, start_early, acq_done};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: test/arf_top_chk.sv
// Port assertions for the result formatter
`timescale 1ns/10ps
`default_nettype none
module arf_top_chk
(
  // Clock, reset and strobes
  input wire logic clk, rst_n, psel, penable, pwrite, pslverr, conversion_done,
  // Address and data
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [9:0] conversion_result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic al, fa, d1, fr;
  logic [9:0] rs, prev_res;
  wire rd = psel & penable & !pwrite;
  wire wr = psel & penable & pwrite;
  wire rb = (paddr == 12'h000) || (paddr == 12'h004);
  // Tracks format and whether the bytes hold the last sample
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      al <= 1'b0;
      d1 <= 1'b0;
      fr <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 12'h00C)
        al <= pwdata[7];
      d1 <= conversion_done;
      fr <= d1 | (fr & !(wr & rb) & !conversion_done);
    end
  // Sample taken one edge before the done pulse, format at the load edge
  always @(posedge clk)
  begin
    prev_res <= conversion_result;
    if (conversion_done)
    begin
      rs <= prev_res;
      fa <= al;
    end
  end
  sequence s_start;
    wr && paddr == 12'h008 && pwdata[1:0] == 2'h3;
  endsequence
  a_start_done: assert property (s_start |-> ##13 conversion_done)
    else $error("no done");
  a_done_pulse: assert property (conversion_done |=> !conversion_done)
    else $error("long done");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h000000)
    else $error("upper bits");
  a_left_high: assert property (rd && paddr == 12'h000 && fr && !fa |-> prdata[7:0] == rs[9:2])
    else $error("left high");
  a_left_low: assert property (rd && paddr == 12'h004 && fr && !fa |-> prdata[7:0] == {rs[1:0], 6'h00})
    else $error("left low");
  a_right_high: assert property (rd && paddr == 12'h000 && fr && fa |-> prdata[7:0] == {6'h00, rs[9:8]})
    else $error("right high");
  a_right_low: assert property (rd && paddr == 12'h004 && fr && fa |-> prdata[7:0] == rs[7:0])
    else $error("right low");
  a_result_ok: assert property (psel && penable && rb |-> !pslverr)
    else $error("result error");
endmodule
bind arf_top arf_top_chk i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pslverr(pslverr), .conversion_done(conversion_done), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .conversion_result(conversion_result));
`default_nettype wire

// file: test/adc_result_formatter_bench.sv
// Register-level tests of the result formatter
`timescale 1ns/10ps
`default_nettype none
module adc_result_formatter_bench;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rv;
  logic [9:0] res = '0;
  wire pready, pslverr, done, en, nref;
  wire [4:0] chan;
  wire [2:0] cks;
  wire [1:0] pref;
  wire [31:0] prdata;
  int fail_count = 0, tests_run = 0, cyc = 0;
  arf_top i_arf_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .conversion_result(res), .converter_enable(en), .input_channel_select(chan), .conversion_clock_select(cks),
    .negative_ref_select(nref), .positive_ref_select(pref), .conversion_done(done));
  initial
    forever #20 clk = ~clk;
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, '0);
    cmp(rv, {24'h000000, e});
  endtask
  task automatic conv(input logic [9:0] r, input logic f);
    res <= r;
    xfer(1'b1, 12'h00C, {24'h000000, f, 7'h00});
    xfer(1'b1, 12'h008, 32'h00000003);
    repeat (14) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b1, 12'h008, 32'h00000001);
    repeat (120) @(posedge clk);
    chk(12'h010, 8'h01);
    conv(10'h2D6, 1'b0);
    chk(12'h008, 8'h01);
    chk(12'h000, 8'hB5);
    chk(12'h004, 8'h80);
    conv(10'h3FF, 1'b0);
    chk(12'h000, 8'hFF);
    chk(12'h004, 8'hC0);
    xfer(1'b1, 12'h000, 32'h0000005A);
    chk(12'h000, 8'h5A);
    conv(10'h155, 1'b1);
    chk(12'h000, 8'h01);
    chk(12'h004, 8'h55);
    xfer(1'b1, 12'h008, 32'h00000055);
    xfer(1'b1, 12'h008, 32'h00000057);
    cmp({26'h0000000, chan, en}, {26'h0000000, 5'h15, 1'b1});
    chk(12'h010, 8'h02);
    repeat (14) @(posedge clk);
    xfer(1'b1, 12'h010, 32'h00000002);
    repeat (120) @(posedge clk);
    chk(12'h010, 8'h01);
    xfer(1'b1, 12'h00C, 32'h0000007F);
    chk(12'h00C, 8'h77);
    cmp({26'h0000000, cks, nref, pref}, {26'h0000000, 3'h7, 1'b1, 2'h3});
    xfer(1'b1, 12'h004, 32'h000000A5);
    chk(12'h020, 8'h00);
    cmp({31'h00000000, er}, 32'h00000001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(12'h00C, 8'h00);
    chk(12'h000, 8'h01);
    chk(12'h004, 8'hA5);
    close_out();
  end
endmodule
`default_nettype wire
